// [logic/bsfb_top.sv]
// bootstrap status, ground reference pairing and feedback blanking registers
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
module bsfb_top
  import bsfb_pkg::*;
#(
  parameter int TIMER_STEP_LOG2 = bsfb_pkg::TMR_STEP_LOG2
)
(
  input  wire logic                                   CLK_SYS,
  input  wire logic                                   ARST_N,
  input  wire logic [11:0]                            PADDR,
  input  wire logic                                   PSEL,
  input  wire logic                                   PENABLE,
  input  wire logic                                   PWRITE,
  input  wire logic [31:0]                            PWDATA,
  output logic      [31:0]                            PRDATA,
  output logic                                        PREADY,
  output logic                                        PSLVERR,
  input  wire logic                                   PREDRIVER_SUPPLY_OK,
  input  wire logic [bsfb_pkg::NUM_HS-1:0]            BS_CHARGE_DET,
  input  wire logic [bsfb_pkg::NUM_LS-1:0]            LOWSIDE_ON,
  input  wire logic [bsfb_pkg::CKPER_W-1:0]           CK_PER,
  input  wire logic [bsfb_pkg::NUM_DAC_WR-1:0]        DAC_WR,
  input  wire logic [bsfb_pkg::NUM_CDAC*bsfb_pkg::FILT_W-1:0] FILTER_LEN,
  input  wire logic [bsfb_pkg::NUM_CDAC-1:0]          FB_CHECK_RAW,
  output logic      [bsfb_pkg::NUM_CDAC-1:0]          FB_CHECK,
  output logic      [bsfb_pkg::NUM_CDAC-1:0]          FB_INVALID,
  output logic      [bsfb_pkg::NUM_HS-1:0]            PAIRED_LOWSIDE_ACTIVE,
  output logic      [bsfb_pkg::NUM_HS-1:0]            BOOTSTRAP_DONE_N,
  output logic                                        SOURCE_THRESHOLD_HIGH
);
  localparam int TMR_W = TMR_FIELD_W + TIMER_STEP_LOG2;

  // pin synchronisers, three stages each
  logic                   sup_s1;
  logic                   sup_s2;
  logic                   sup_s3;
  logic                   supply_stable;
  logic [NUM_HS-1:0]      det_s1;
  logic [NUM_HS-1:0]      det_s2;
  logic [NUM_HS-1:0]      det_s3;
  logic [NUM_HS-1:0]      charge_det;
  // startup timer and status
  logic [TMR_W-1:0]       timer;
  logic [TMR_FIELD_W-1:0] timer_field;
  logic                   timer_expired;
  logic [NUM_HS-1:0]      bootstrap_done_n;
  logic [NUM_HS-1:0]      threshold_raised;
  // configuration
  logic [GREF_W-1:0]      gref [NUM_HS];
  logic [SETTLE_W-1:0]    settle_time;
  // core clock enable
  logic [CKPER_W-1:0]     ck_div;
  logic                   ck_en;
  // feedback blanking
  logic [NUM_CDAC-1:0]    blanking;
  // bus decode
  logic [IDX_W-1:0]       idx;
  logic                   acc;
  logic                   wr_en;
  logic                   hit;
  logic [15:0]            rd_val;
  logic [15:0]            status_word;
  logic [15:0]            timer_word;

  // supply good pin: change accepted when stages two and three agree
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sup_s1        <= 1'b0;
      sup_s2        <= 1'b0;
      sup_s3        <= 1'b0;
      supply_stable <= 1'b0;
    end
    else
    begin
      sup_s1 <= PREDRIVER_SUPPLY_OK;
      sup_s2 <= sup_s1;
      sup_s3 <= sup_s2;
      if (sup_s2 == sup_s3)
        supply_stable <= sup_s3;
    end
  end

  // charge comparator pins, same filtering per high side
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      det_s1     <= '0;
      det_s2     <= '0;
      det_s3     <= '0;
      charge_det <= '0;
    end
    else
    begin
      det_s1 <= BS_CHARGE_DET;
      det_s2 <= det_s1;
      det_s3 <= det_s2;
      for (int i = 0; i < NUM_HS; i++)
        if (det_s2[i] == det_s3[i])
          charge_det[i] <= det_s3[i];
    end
  end

  // upper bits of the startup timer
  assign timer_field   = timer[TMR_W-1 -: TMR_FIELD_W];
  assign timer_expired = (timer_field == TMR_FINAL);

  // startup timer: counts system cycles while supply is stable
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      timer <= '0;
    else if (!supply_stable)
      timer <= '0;
    else if (!timer_expired)
      timer <= timer + TMR_W'(1);
  end

  // source threshold select: 0.5 V low, 1.0 V once expired
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      SOURCE_THRESHOLD_HIGH <= 1'b0;
    else
      SOURCE_THRESHOLD_HIGH <= timer_expired;
  end

  // per high side charge status pair
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      bootstrap_done_n <= BS_DONE_RESET;
      threshold_raised <= BS_RAISED_RESET;
    end
    else if (!supply_stable)
    begin
      bootstrap_done_n <= BS_DONE_RESET;
      threshold_raised <= BS_RAISED_RESET;
    end
    else
    begin
      for (int i = 0; i < NUM_HS; i++)
        if (bootstrap_done_n[i])
        begin
          // threshold in use is recorded until the charge is seen
          threshold_raised[i] <= SOURCE_THRESHOLD_HIGH;
          if (charge_det[i])
            bootstrap_done_n[i] <= 1'b0;
        end
    end
  end

  assign BOOTSTRAP_DONE_N = bootstrap_done_n;

  // paired low side activity per high side
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      PAIRED_LOWSIDE_ACTIVE <= '0;
    else
      for (int i = 0; i < NUM_HS; i++)
        PAIRED_LOWSIDE_ACTIVE[i] <= !gref[i][GREF_DIS_BIT]
          && |(gref[i][GREF_SEL_LSB +: NUM_LS] & LOWSIDE_ON);
  end

  // core clock enable from the prescaler, period CK_PER+1
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ck_div <= '0;
      ck_en  <= 1'b0;
    end
    else if (ck_div >= CK_PER)
    begin
      ck_div <= '0;
      ck_en  <= 1'b1;
    end
    else
    begin
      ck_div <= ck_div + CKPER_W'(1);
      ck_en  <= 1'b0;
    end
  end

  // one blanking counter per current DAC; boost DAC has none
  for (genvar d = 0; d < NUM_CDAC; d++)
  begin : g_blank
    bsfb_blank u_blank (
      .clk      (CLK_SYS),
      .arst_n   (ARST_N),
      .dac_wr   (DAC_WR[d]),
      .ck_en    (ck_en),
      .settle   (settle_time),
      .filt_len (FILTER_LEN[d*FILT_W +: FILT_W]),
      .blanking (blanking[d])
    );
  end

  // feedback checks forced false while blanked
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      FB_CHECK   <= '0;
      FB_INVALID <= '0;
    end
    else
    begin
      FB_CHECK   <= FB_CHECK_RAW & ~blanking;
      FB_INVALID <= blanking;
    end
  end

  // bus decode: word index, zero wait states
  assign idx     = PADDR[11:2];
  assign acc     = PSEL && PENABLE;
  assign wr_en   = acc && PWRITE && hit;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && !hit;

  // ground reference registers for high sides 1 to 7
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int i = 0; i < NUM_HS; i++)
        gref[i] <= GREF_RESET;
    end
    else if (wr_en)
    begin
      for (int i = 0; i < NUM_HS; i++)
        if (idx == IDX_GREF_FIRST + IDX_W'(i))
          gref[i] <= PWDATA[GREF_W-1:0];
    end
  end

  // settling count register
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      settle_time <= SETTLE_RESET;
    else if (wr_en && idx == IDX_SETTLE)
      settle_time <= PWDATA[SETTLE_W-1:0];
  end

  // read words of the status registers
  always_comb
  begin
    status_word = '0;
    status_word[BS_DONE_LSB +: NUM_HS]   = bootstrap_done_n;
    status_word[BS_RAISED_LSB +: NUM_HS] = threshold_raised;
    timer_word  = '0;
    timer_word[TMR_FIELD_LSB +: TMR_FIELD_W] = timer_field;
  end

  // address hit and read value
  always_comb
  begin
    hit    = 1'b1;
    rd_val = '0;
    if (idx == IDX_BS_STATUS)
      rd_val = status_word;
    else if (idx == IDX_BS_TIMER)
      rd_val = timer_word;
    else if (idx >= IDX_GREF_FIRST && idx <= IDX_GREF_LAST)
      rd_val = {8'h00, gref[3'(idx - IDX_GREF_FIRST)]};
    else if (idx == IDX_SETTLE)
      rd_val = {10'h000, settle_time};
    else
      hit = 1'b0;
  end

  // read data held from a flip-flop
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      PRDATA <= '0;
    else if (PSEL && !PENABLE && !PWRITE)
      PRDATA <= {16'h0000, rd_val};
  end
endmodule

// [logic/bsfb_pkg.sv]
// constants shared by the bootstrap status and feedback blanking register bank
// Behaviour
// - per high side, bootstrap_done_n reads zero once its capacitor charge is detected
// - per high side, threshold_raised is set when 1.0 V was needed to finish
// - timer register shows the live six top bits of the startup timer
// - timer counts as expired when its top bits reach 110100
// - timer field stays 000000 while the predriver supply is not stable
// - timer counts clock cycles from supply stable; one field step is 2^14 cycles
// - source threshold is 0.5 V before expiry and 1.0 V after it
// - status pair one/zero means uncharged, timer running; this is the reset state
// - pair one/one means uncharged, timer lapsed; zero done means charged
// - timer durations scale with the system clock rate
// - seven ground reference registers for high sides 1 to 7 at 18Fh to 195h
// - paired_lowside_active is high when any selected low side is on
// - pairing_disable (bit 7) forces paired_lowside_active to zero
// - while blanking runs, every feedback check on that DAC reads false
// - boost DAC writes never start a blanking interval
// - a DAC write blanks for blanking count plus filter depth plus 4 core periods
// - each DAC uses its own filter depth for its blanking length
package bsfb_pkg;
  // sizes of the block
  localparam int NUM_HS        = 7;
  localparam int NUM_LS        = 7;
  localparam int NUM_CDAC      = 6;
  localparam int NUM_DAC_WR    = 7;
  localparam int BOOST_DAC_IDX = 6;
  localparam int FILT_W        = 4;
  localparam int SETTLE_W      = 6;
  localparam int BLANK_W       = 8;
  localparam int CKPER_W       = 6;
  // register indices; byte address is four times the index
  localparam int         IDX_W          = 10;
  localparam logic [9:0] IDX_BS_STATUS  = 10'h18D;
  localparam logic [9:0] IDX_BS_TIMER   = 10'h18E;
  localparam logic [9:0] IDX_GREF_FIRST = 10'h18F;
  localparam logic [9:0] IDX_GREF_LAST  = 10'h195;
  localparam logic [9:0] IDX_SETTLE     = 10'h196;
  // status register field layout
  localparam int BS_DONE_LSB   = 0;
  localparam int BS_RAISED_LSB = 8;
  // timer register field layout
  localparam int         TMR_FIELD_W   = 6;
  localparam int         TMR_FIELD_LSB = 10;
  localparam logic [5:0] TMR_FINAL     = 6'h34;
  localparam logic [5:0] TMR_ZERO      = 6'h00;
  localparam int         TMR_STEP_LOG2 = 14;
  // ground reference register layout
  localparam int         GREF_SEL_LSB = 0;
  localparam int         GREF_DIS_BIT = 7;
  localparam int         GREF_W       = 8;
  localparam logic [7:0] GREF_RESET   = 8'hFF;
  // settling register layout
  localparam logic [5:0] SETTLE_RESET = 6'h00;
  localparam logic [7:0] BLANK_EXTRA  = 8'h04;
  // reset values of status bits
  localparam logic [6:0] BS_DONE_RESET   = 7'h7F;
  localparam logic [6:0] BS_RAISED_RESET = 7'h00;
endpackage

// [logic/bsfb_blank.sv]
// one feedback blanking counter for one current DAC
`timescale 1ns/100ps
module bsfb_blank
  import bsfb_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          dac_wr,
  input  wire logic                          ck_en,
  input  wire logic [bsfb_pkg::SETTLE_W-1:0] settle,
  input  wire logic [bsfb_pkg::FILT_W-1:0]   filt_len,
  output logic                               blanking
);
  logic [BLANK_W-1:0] count;
  logic [BLANK_W-1:0] next_count;

  // full interval length from this DAC's own filter depth
  always_comb
  begin
    next_count = BLANK_W'(settle) + BLANK_W'(filt_len) + BLANK_EXTRA;
  end

  // load on write, count down on core clock periods
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      count <= '0;
    else if (dac_wr)
      count <= next_count;
    else if (ck_en && count != '0)
      count <= count - 8'h01;
  end

  assign blanking = (count != '0);
endmodule

// [tb/bsfb_props.sv]
// checker for the bootstrap status and feedback blanking register bank
`timescale 1ns/100ps
module bsfb_props
  import bsfb_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  input wire logic [11:0] PADDR,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PSLVERR,
  input wire logic        PREDRIVER_SUPPLY_OK,
  input wire logic [6:0]  BS_CHARGE_DET,
  input wire logic [6:0]  LOWSIDE_ON,
  input wire logic [6:0]  DAC_WR,
  input wire logic [5:0]  FB_CHECK_RAW,
  input wire logic [5:0]  FB_CHECK,
  input wire logic [5:0]  FB_INVALID,
  input wire logic [6:0]  PAIRED_LOWSIDE_ACTIVE,
  input wire logic [6:0]  BOOTSTRAP_DONE_N,
  input wire logic        SOURCE_THRESHOLD_HIGH
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // bus decode, pairing and masking relations
  decode_err_a: assert property (PSEL && PENABLE |->
    PSLVERR == !(PADDR[11:2] inside {[IDX_BS_STATUS:IDX_SETTLE]})) else $error("bad decode");
  pair_cause_a: assert property (|PAIRED_LOWSIDE_ACTIVE |-> |$past(LOWSIDE_ON))
    else $error("pairing without low side");
  fb_mask_a: assert property (FB_CHECK == ($past(FB_CHECK_RAW) & ~FB_INVALID))
    else $error("feedback not masked");
  // blanking start, length and boost exclusion
  blank_start_a: assert property (|DAC_WR[5:0] |-> ##2
    (FB_INVALID & $past(DAC_WR[5:0], 2)) == $past(DAC_WR[5:0], 2)) else $error("no blanking");
  blank_min_a: assert property ($rose(FB_INVALID[0]) |-> FB_INVALID[0] [*3])
    else $error("blanking too short");
  boost_skip_a: assert property (DAC_WR == 7'h40 && $past(DAC_WR) == 7'h00
    && FB_INVALID == 6'h00 |-> ##2 FB_INVALID == 6'h00) else $error("boost blanked");
  // bootstrap status and threshold
  done_cause_a: assert property ($fell(BOOTSTRAP_DONE_N[0]) |-> $past(BS_CHARGE_DET[0], 3))
    else $error("done without charge");
  thr_rise_a: assert property ($rose(SOURCE_THRESHOLD_HIGH) |->
    $past(PREDRIVER_SUPPLY_OK, 200)) else $error("threshold raised early");
  thr_low_a: assert property (!PREDRIVER_SUPPLY_OK [*8] |-> !SOURCE_THRESHOLD_HIGH)
    else $error("threshold high without supply");
  cover property (PAIRED_LOWSIDE_ACTIVE != 7'h00);
  cover property ($rose(SOURCE_THRESHOLD_HIGH));
  cover property ($fell(FB_INVALID[1]));
endmodule
bind bsfb_top bsfb_props i_bsfb_props (.CLK_SYS, .ARST_N, .PADDR, .PSEL, .PENABLE, .PSLVERR,
  .PREDRIVER_SUPPLY_OK, .BS_CHARGE_DET, .LOWSIDE_ON, .DAC_WR, .FB_CHECK_RAW, .FB_CHECK,
  .FB_INVALID, .PAIRED_LOWSIDE_ACTIVE, .BOOTSTRAP_DONE_N, .SOURCE_THRESHOLD_HIGH);

// [tb/bsfb_host.sv]
// host model: apb master reaching the register bank
`timescale 1ns/100ps
module bsfb_host (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic      [11:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata
);
  // bus idle at time zero
  initial {paddr, psel, penable, pwrite, pwdata} = '0;
  // one transfer: setup, then access held until pready, bounded
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output bit to);
    int n = 0;
    @(posedge clk);
    paddr <= {idx, 2'b00};
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// [tb/bsfb_top_tb.sv]
// self-checking bench for the bootstrap status and feedback blanking bank
`timescale 1ns/100ps
module bsfb_top_tb;
  import bsfb_pkg::*;
  logic        CLK_SYS = 1'b0;
  logic        ARST_N = 1'b0;
  logic [11:0] PADDR;
  logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PREDRIVER_SUPPLY_OK;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic [6:0]  BS_CHARGE_DET, LOWSIDE_ON, DAC_WR, PAIRED_LOWSIDE_ACTIVE, BOOTSTRAP_DONE_N;
  logic [5:0]  CK_PER, FB_CHECK_RAW, FB_CHECK, FB_INVALID;
  logic [23:0] FILTER_LEN;
  logic        SOURCE_THRESHOLD_HIGH;
  bit          to;
  int          n_errors = 0, n_tests = 0, n;
  bsfb_top #(.TIMER_STEP_LOG2(2)) i_bsfb_top (.CLK_SYS, .ARST_N, .PADDR, .PSEL, .PENABLE,
    .PWRITE, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .PREDRIVER_SUPPLY_OK, .BS_CHARGE_DET,
    .LOWSIDE_ON, .CK_PER, .DAC_WR, .FILTER_LEN, .FB_CHECK_RAW, .FB_CHECK, .FB_INVALID,
    .PAIRED_LOWSIDE_ACTIVE, .BOOTSTRAP_DONE_N, .SOURCE_THRESHOLD_HIGH);
  bsfb_host i_bsfb_host (.clk(CLK_SYS), .pready(PREADY), .prdata(PRDATA), .paddr(PADDR),
    .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .pwdata(PWDATA));
  // 200 MHz clock
  always #2.5 CLK_SYS = ~CLK_SYS;
  task automatic wrap_up();
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // bus access; a hung bus ends the run
  task automatic xf(input logic w, input logic [9:0] idx, input logic [31:0] d);
    i_bsfb_host.xfer(w, idx, d, rdat, to);
    if (to)
    begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] e, input string nm);
    xf(1'b0, idx, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge CLK_SYS);
  endtask
  // one dac write pulse, then count blanked cycles in a fixed window
  task automatic blen(input logic [6:0] w, input int d, output int cnt);
    @(posedge CLK_SYS) DAC_WR <= w;
    @(posedge CLK_SYS) DAC_WR <= 7'h00;
    cnt = 0;
    repeat (100)
    begin
      @(negedge CLK_SYS);
      if (FB_INVALID[d] === 1'b1) cnt++;
    end
  endtask
  initial
  begin
    {PREDRIVER_SUPPLY_OK, BS_CHARGE_DET, LOWSIDE_ON, CK_PER, DAC_WR, FB_CHECK_RAW} = '0;
    FILTER_LEN = 24'h000073;
    repeat (20) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    // reset values, decode and read-only status
    rd(IDX_BS_STATUS, 32'h7F, "status");
    rd(IDX_BS_TIMER, 32'h0, "timer");
    for (int i = 0; i < 7; i++)
      rd(IDX_GREF_FIRST + 10'(i), 32'hFF, "gref");
    rd(10'h197, 32'h0, "unmapped");
    xf(1'b1, IDX_BS_STATUS, 32'hFFFF);
    rd(IDX_BS_STATUS, 32'h7F, "status_ro");
    // each high side paired with its own low side
    for (int i = 0; i < 7; i++)
      xf(1'b1, IDX_GREF_FIRST + 10'(i), 32'(1 << i));
    @(posedge CLK_SYS) LOWSIDE_ON <= 7'h01;
    cyc(3);
    chk("paired", 32'h01, 32'(PAIRED_LOWSIDE_ACTIVE));
    @(posedge CLK_SYS) LOWSIDE_ON <= 7'h7E;
    xf(1'b1, IDX_GREF_FIRST + 10'd1, 32'h82);
    cyc(3);
    chk("paired_dis", 32'h7C, 32'(PAIRED_LOWSIDE_ACTIVE));
    rd(IDX_GREF_FIRST + 10'd1, 32'h82, "gref_rb");
    // startup timer, charge status and threshold
    @(posedge CLK_SYS) PREDRIVER_SUPPLY_OK <= 1'b1;
    cyc(100);
    chk("thr_early", 32'h0, 32'(SOURCE_THRESHOLD_HIGH));
    xf(1'b0, IDX_BS_TIMER, 32'h0);
    chk("timer_mid", 1, 32'(rdat[15:10] > 6'h00 && rdat[15:10] < TMR_FINAL));
    @(posedge CLK_SYS) BS_CHARGE_DET <= 7'h01;
    cyc(10);
    rd(IDX_BS_STATUS, 32'h7E, "status_hs1");
    cyc(150);
    rd(IDX_BS_TIMER, 32'hD000, "timer_end");
    chk("thr_late", 32'h1, 32'(SOURCE_THRESHOLD_HIGH));
    @(posedge CLK_SYS) BS_CHARGE_DET <= 7'h03;
    cyc(10);
    rd(IDX_BS_STATUS, 32'h7E7C, "status_hs2");
    rd(IDX_BS_TIMER, 32'hD000, "timer_sat");
    @(posedge CLK_SYS) {PREDRIVER_SUPPLY_OK, BS_CHARGE_DET} <= '0;
    cyc(10);
    rd(IDX_BS_TIMER, 32'h0, "timer_loss");
    rd(IDX_BS_STATUS, 32'h7F, "status_loss");
    // feedback blanking per dac, boost excluded, restart
    xf(1'b1, IDX_SETTLE, 32'h2);
    @(posedge CLK_SYS) FB_CHECK_RAW <= 6'h3F;
    blen(7'h01, 0, n);
    chk("blank_dac0", 1, 32'(n inside {[8:10]}));
    blen(7'h02, 1, n);
    chk("blank_dac1", 1, 32'(n inside {[12:14]}));
    blen(7'h40, 0, n);
    chk("blank_boost", 0, n);
    @(posedge CLK_SYS) CK_PER <= 6'd3;
    blen(7'h01, 0, n);
    chk("blank_slow", 1, 32'(n inside {[32:40]}));
    @(posedge CLK_SYS) DAC_WR <= 7'h01;
    @(posedge CLK_SYS) DAC_WR <= 7'h00;
    cyc(8);
    blen(7'h01, 0, n);
    chk("blank_restart", 1, 32'(n inside {[32:40]}));
    chk("fb_pass", 32'h3F, 32'(FB_CHECK));
    wrap_up();
  end
endmodule
